/* File: core/hvr_regs.sv */
// Purpose: indirect high-voltage configuration and status bank
// Assumes: core reaches it through command and data registers only
// Notes: analog comparators arrive as raw asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - config bit 4 enables the supply-drop flag function
// R2 - config bit 3 turns on the attenuator diagnostic current source
// R3 - writing 1 to config bit 2 re-enables driver, bit self-clears
// R4 - passive mode: short raises interrupt, sets status, driver stays on
// R5 - active mode: short raises interrupt, sets status, disables driver
// R6 - short counts only after persisting longer than 20 us
// R7 - config bit 0 selects LIN disabled or enabled
// R8 - status register reachable only via indirect command and data
// R9 - interrupt event copies status into data register at once; copy deferred until idle if a transfer is busy or starting
// R10 - software reads status only in response to the interrupt
// R11 - status bit 2 is 0 after supply drop, else 1
// R12 - status bit 2 meaningful only while config bit 4 set
// R13 - bit 2 changes only on supply drop or flag re-enable
// R14 - status bit 0 set on short, cleared by status read
// R15 - status bits 7..3, 1 and config bits 7..5 reserved
// R16 - command bit 0 busy during transfer, clears after 10 us
// R17 - software checks command bit 1 before reading data
// R18 - reserved bits read 0, reserved config writes ignored
module hvr_regs
(
   input wire logic clock, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic ce, // clock enable, freezes state
   input wire logic cmd_wr, // write strobe, command register
   input wire logic [7:0] cmd_wdata, // command code
   output logic [7:0] cmd_rdata, // command readback, busy and ok
   input wire logic dat_wr, // write strobe, data register
   input wire logic [7:0] dat_wdata, // data written by software
   output logic [7:0] dat_rdata, // data register readback
   input wire logic irq_enable_mask, // high-voltage interrupt enable
   input wire logic lin_short_raw, // raw short comparator, async
   input wire logic supply_low_raw, // core supply below 2.1 V, async
   output logic hv_irq, // one-cycle interrupt event
   output logic lin_enable, // LIN operating state
   output logic lin_driver_on, // LIN driver actually enabled
   output logic atten_diag_on // attenuator current source on
);
   // ****************************************************
   // short-circuit qualification
   // ****************************************************
   hvr_short_if sif ();

   hvr_short_filter u_filt
   (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .lin_short_raw(lin_short_raw),
      .sif(sif)
   );

   // ****************************************************
   // supply comparator synchroniser
   // ****************************************************
   logic sup1_r;
   logic sup2_r;

   // two-stage sync of supply-drop level
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sup1_r <= 1'b0;
         sup2_r <= 1'b0;
      end
      else if (ce)
      begin
         sup1_r <= supply_low_raw;
         sup2_r <= sup1_r;
      end
   end

   // ****************************************************
   // state declarations
   // ****************************************************
   hvr_pkg::hvr_state_t state_r;
   hvr_pkg::hvr_state_t state_nxt;
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic short_r;
   logic short_nxt;
   logic lvf_r;
   logic lvf_nxt;
   logic drv_ok_r;
   logic drv_ok_nxt;
   logic [7:0] dat_r;
   logic [7:0] dat_nxt;
   logic [7:0] tmr_r;
   logic [7:0] tmr_nxt;
   logic ok_r;
   logic ok_nxt;
   logic pend_r;
   logic pend_nxt;
   logic irq_r;
   logic irq_nxt;
   logic lin_en_r;
   logic drv_on_r;
   logic diag_r;
   logic [7:0] sta_view;
   logic start_cmd;
   logic start_auto;

   // assemble visible status byte
   function automatic logic [7:0] status_byte(input logic shrt,
                                              input logic supply_drop_flag,
                                              input logic lvf_en);
      logic [7:0] v;
      v = 8'h00;
      v[hvr_pkg::STA_SHORT_BIT] = shrt;
      v[hvr_pkg::STA_LVF_BIT] = supply_drop_flag & lvf_en;
      return v;
   endfunction

   // R1 R12 bit 2 masked when off
   // R15 reserved status bits held zero
   assign sta_view = status_byte(short_r, lvf_r,
                                 cfg_r[hvr_pkg::CFG_LVF_EN_BIT]);

   // command accepted only while idle
   assign start_cmd = cmd_wr && (state_r == hvr_pkg::HVR_IDLE);
   // auto load starts when idle and no command competes
   assign start_auto = pend_r && !cmd_wr &&
                       (state_r == hvr_pkg::HVR_IDLE);

   // ****************************************************
   // transfer engine and registers, next values
   // ****************************************************
   always_comb
   begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      short_nxt = short_r;
      lvf_nxt = lvf_r;
      drv_ok_nxt = drv_ok_r;
      dat_nxt = dat_r;
      tmr_nxt = tmr_r;
      ok_nxt = ok_r;
      pend_nxt = pend_r;
      irq_nxt = 1'b0;

      // software loads data register while idle
      if (dat_wr && (state_r == hvr_pkg::HVR_IDLE))
      begin
         dat_nxt = dat_wdata;
      end

      case (state_r)
         hvr_pkg::HVR_IDLE:
         begin
            if (start_cmd)
            begin
               state_nxt = hvr_pkg::HVR_BUSY;
               tmr_nxt = hvr_pkg::BUSY_CYC;
               ok_nxt = 1'b1;
               case (cmd_wdata)
                  hvr_pkg::CMD_READ_CFG:
                  begin
                     dat_nxt = cfg_r;
                  end
                  hvr_pkg::CMD_WRITE_CFG:
                  begin
                     // R18 reserved config bits dropped
                     cfg_nxt = dat_r & hvr_pkg::CFG_USED_MASK;
                     // R3 re-enable, bit not stored
                     if (dat_r[hvr_pkg::CFG_REEN_BIT])
                     begin
                        drv_ok_nxt = 1'b1;
                     end
                     cfg_nxt[hvr_pkg::CFG_REEN_BIT] = 1'b0;
                     // R13 flag rearmed on enable edge
                     if (dat_r[hvr_pkg::CFG_LVF_EN_BIT] &&
                         !cfg_r[hvr_pkg::CFG_LVF_EN_BIT])
                     begin
                        lvf_nxt = 1'b1;
                     end
                  end
                  hvr_pkg::CMD_READ_STA:
                  begin
                     // R8 status only via data register
                     dat_nxt = sta_view;
                     // R14 read clears short flag
                     short_nxt = 1'b0;
                  end
                  default:
                  begin
                     ok_nxt = 1'b0;
                  end
               endcase
            end
            else if (start_auto)
            begin
               // R9 deferred status copy once idle
               state_nxt = hvr_pkg::HVR_BUSY;
               tmr_nxt = hvr_pkg::BUSY_CYC;
               ok_nxt = 1'b1;
               pend_nxt = 1'b0;
               dat_nxt = sta_view;
               short_nxt = 1'b0;
            end
         end
         hvr_pkg::HVR_BUSY:
         begin
            // R16 busy for the transfer time
            if (tmr_r == 8'h01)
            begin
               state_nxt = hvr_pkg::HVR_IDLE;
               tmr_nxt = 8'h00;
            end
            else
            begin
               tmr_nxt = tmr_r - 8'h01;
            end
         end
         default:
         begin
            state_nxt = hvr_pkg::HVR_IDLE;
            tmr_nxt = 8'h00;
         end
      endcase

      // R11 supply drop clears the flag
      if (sup2_r && cfg_nxt[hvr_pkg::CFG_LVF_EN_BIT])
      begin
         lvf_nxt = 1'b0;
      end

      // short event: set wins over any clear above
      if (sif.detect)
      begin
         // R14 short sets status bit 0
         short_nxt = 1'b1;
         // R4 passive keeps driver, R5 active drops it
         if (!cfg_nxt[hvr_pkg::CFG_PASSIVE_BIT])
         begin
            drv_ok_nxt = 1'b0;
         end
         if (irq_enable_mask)
         begin
            // R4 interrupt only when enabled
            irq_nxt = 1'b1;
            // R9 capture straight away when idle
            if ((state_r == hvr_pkg::HVR_IDLE) && !start_cmd &&
                !start_auto)
            begin
               state_nxt = hvr_pkg::HVR_BUSY;
               tmr_nxt = hvr_pkg::BUSY_CYC;
               ok_nxt = 1'b1;
               dat_nxt = status_byte(1'b1, lvf_r,
                                     cfg_r[hvr_pkg::CFG_LVF_EN_BIT]);
               short_nxt = 1'b0;
            end
            else
            begin
               pend_nxt = 1'b1;
            end
         end
      end
   end

   // ****************************************************
   // state registers
   // ****************************************************
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_r <= hvr_pkg::HVR_IDLE;
         cfg_r <= hvr_pkg::CFG_RESET;
         short_r <= 1'b0;
         lvf_r <= 1'b0;
         drv_ok_r <= 1'b1;
         dat_r <= hvr_pkg::DAT_RESET;
         tmr_r <= 8'h00;
         ok_r <= 1'b0;
         pend_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         short_r <= short_nxt;
         lvf_r <= lvf_nxt;
         drv_ok_r <= drv_ok_nxt;
         dat_r <= dat_nxt;
         tmr_r <= tmr_nxt;
         ok_r <= ok_nxt;
         pend_r <= pend_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ****************************************************
   // registered control outputs
   // ****************************************************
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         lin_en_r <= 1'b0;
         drv_on_r <= 1'b0;
         diag_r <= 1'b0;
      end
      else if (ce)
      begin
         // R7 LIN operating state
         lin_en_r <= cfg_nxt[hvr_pkg::CFG_LIN_EN_BIT];
         drv_on_r <= cfg_nxt[hvr_pkg::CFG_LIN_EN_BIT] & drv_ok_nxt;
         // R2 diagnostic current source
         diag_r <= cfg_nxt[hvr_pkg::CFG_DIAG_BIT];
      end
   end

   // ****************************************************
   // readback and outputs
   // ****************************************************
   // R16 busy and ok flags in command register
   always_comb
   begin
      cmd_rdata = 8'h00;
      cmd_rdata[hvr_pkg::CMD_BUSY_BIT] = (state_r == hvr_pkg::HVR_BUSY);
      cmd_rdata[hvr_pkg::CMD_OK_BIT] = ok_r;
   end

   assign dat_rdata = dat_r;
   assign hv_irq = irq_r;
   assign lin_enable = lin_en_r;
   assign lin_driver_on = drv_on_r;
   assign atten_diag_on = diag_r;
endmodule
`default_nettype wire

/* File: pkg/hvr_pkg.sv */
// Purpose: shared constants of the high-voltage config/status bank
// Assumes: 20 MHz system clock
// Notes: indirect command codes and timing counts live here
package hvr_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int BUSY_TIME_NS = 10000;
   localparam int SHORT_TIME_NS = 20000;
   // longest wait rounds down, least persistence rounds up
   localparam int BUSY_CYC_I = BUSY_TIME_NS / CLK_PERIOD_NS;
   localparam int SHORT_CYC_I =
      (SHORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] BUSY_CYC = BUSY_CYC_I[7:0];
   localparam logic [8:0] SHORT_CYC = SHORT_CYC_I[8:0];

   // indirect command codes
   localparam logic [7:0] CMD_READ_CFG = 8'h00;
   localparam logic [7:0] CMD_WRITE_CFG = 8'h01;
   localparam logic [7:0] CMD_READ_STA = 8'h02;

   // indirect command register fields
   localparam int CMD_BUSY_BIT = 0;
   localparam int CMD_OK_BIT = 1;

   // hv_configuration fields
   localparam int CFG_LIN_EN_BIT = 0;
   localparam int CFG_PASSIVE_BIT = 1;
   localparam int CFG_REEN_BIT = 2;
   localparam int CFG_DIAG_BIT = 3;
   localparam int CFG_LVF_EN_BIT = 4;
   localparam logic [7:0] CFG_USED_MASK = 8'h1f;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // hv_status fields
   localparam int STA_SHORT_BIT = 0;
   localparam int STA_LVF_BIT = 2;
   localparam logic [7:0] STA_RESET = 8'h00;
   localparam logic [7:0] DAT_RESET = 8'h00;

   // transfer engine states
   typedef enum logic [1:0]
   {
      HVR_IDLE = 2'b01,
      HVR_BUSY = 2'b10
   } hvr_state_t;
endpackage

/* File: pkg/hvr_short_if.sv */
// Purpose: carries the filtered short-circuit event to the core
// Assumes: one clock domain
// Notes: detect is a one-cycle pulse per qualified short
`timescale 1ns/1ps
`default_nettype none
interface hvr_short_if;
   logic detect;
   logic active;
   modport filt (output detect, output active);
   modport core (input detect, input active);
endinterface
`default_nettype wire

/* File: core/hvr_short_filter.sv */
// Purpose: qualifies the raw LIN short comparator by persistence
// Assumes: raw input is asynchronous to clock
// Notes: one detect pulse per short, rearmed when the short ends
`timescale 1ns/1ps
`default_nettype none
module hvr_short_filter
(
   input wire logic clock, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic ce, // clock enable
   input wire logic lin_short_raw, // raw short comparator
   hvr_short_if.filt sif // filtered event out
);
   logic sync1_r;
   logic sync2_r;
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   logic done_r;
   logic done_nxt;
   logic det_r;
   logic det_nxt;

   // count cycles of continuous short
   always_comb
   begin
      cnt_nxt = cnt_r;
      done_nxt = done_r;
      det_nxt = 1'b0;
      if (!sync2_r)
      begin
         cnt_nxt = 9'h000;
         done_nxt = 1'b0;
      end
      else if (!done_r)
      begin
         // R6 longer than persistence
         if (cnt_r == hvr_pkg::SHORT_CYC)
         begin
            det_nxt = 1'b1;
            done_nxt = 1'b1;
         end
         else
         begin
            cnt_nxt = cnt_r + 9'h001;
         end
      end
   end

   // synchroniser and counter registers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         cnt_r <= 9'h000;
         done_r <= 1'b0;
         det_r <= 1'b0;
      end
      else if (ce)
      begin
         sync1_r <= lin_short_raw;
         sync2_r <= sync1_r;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         det_r <= det_nxt;
      end
   end

   assign sif.detect = det_r & ce;
   assign sif.active = done_r;
endmodule
`default_nettype wire

/* File: testbench/hvr_regs_props.sv */
// Purpose: port checks of the config/status bank
// Assumes: clock enable held high
// Notes: bound to hvr_regs from the bench top
`timescale 1ns/1ps
`default_nettype none
module hvr_regs_props
(
   input wire logic clock, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic cmd_wr, // command strobe
   input wire logic [7:0] cmd_rdata, // busy and ok
   input wire logic [7:0] dat_rdata, // data register
   input wire logic irq_enable_mask, // irq enable
   input wire logic lin_short_raw, // raw short
   input wire logic hv_irq, // irq event
   input wire logic lin_enable, // LIN state
   input wire logic lin_driver_on // driver state
);
   logic [8:0] run_r, run_nxt, last_r, last_nxt;
   logic [7:0] bsy_r, bsy_nxt;
   // ****************
   // helper counters
   // ****************
   // short run length, busy length
   always_comb
   begin
      run_nxt = lin_short_raw ? run_r + {8'h0, ~&run_r} : 9'h0;
      last_nxt = (run_r != 9'h0 && !lin_short_raw) ? run_r : last_r;
      if (hv_irq)
         last_nxt = 9'h0;
      bsy_nxt = cmd_rdata[0] ? bsy_r + 8'h1 : 8'h0;
      if (!rst_n)
      begin
         run_nxt = 9'h0;
         last_nxt = 9'h0;
         bsy_nxt = 8'h0;
      end
   end
   // registers only
   always_ff @(posedge clock)
   begin
      run_r <= run_nxt;
      last_r <= last_nxt;
      bsy_r <= bsy_nxt;
   end
   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   busy_start_a: assert property (
      cmd_wr && !cmd_rdata[0] |=> cmd_rdata[0])
      else $error("busy did not follow a command");
   busy_len_a: assert property (
      $fell(cmd_rdata[0]) |-> bsy_r == 8'hc8)
      else $error("busy length is not 200 cycles");
   irq_load_a: assert property (
      hv_irq |-> cmd_rdata[0] && dat_rdata[0])
      else $error("irq without status load");
   irq_pulse_a: assert property (
      hv_irq |=> !hv_irq)
      else $error("irq longer than one cycle");
   irq_mask_a: assert property (
      hv_irq |-> $past(irq_enable_mask))
      else $error("irq while masked");
   short_long_a: assert property (
      hv_irq |-> run_r > 9'h190 || last_r > 9'h190)
      else $error("irq from a short below 20 us");
   drv_needs_lin_a: assert property (
      lin_driver_on |-> lin_enable)
      else $error("driver on with LIN off");
   drv_rise_a: assert property (
      $rose(lin_driver_on) |-> cmd_rdata[0] || $past(cmd_rdata[0]))
      else $error("driver on without a config write");
   cmd_reserved_a: assert property (
      cmd_rdata[7:2] == 6'h00)
      else $error("reserved command bits not 0");
   irq_c: cover property (hv_irq);
   drv_off_c: cover property ($fell(lin_driver_on));
   busy_end_c: cover property ($fell(cmd_rdata[0]));
endmodule
`default_nettype wire

/* File: testbench/hvr_core_model.sv */
// Purpose: processor side of the indirect command interface
// Assumes: one command strobe per request
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module hvr_core_model
(
   input wire logic clock, // system clock
   input wire logic [7:0] cmd_rdata, // busy and ok
   input wire logic [7:0] dat_rdata, // data register
   output var logic cmd_wr, // command strobe
   output var logic [7:0] cmd_wdata, // command code
   output var logic dat_wr, // data strobe
   output var logic [7:0] dat_wdata // data byte
);
   // idle bus at time zero
   initial
   begin
      cmd_wr = 1'b0;
      cmd_wdata = 8'h00;
      dat_wr = 1'b0;
      dat_wdata = 8'h00;
   end
   // status only through command and data
   task automatic issue(input logic [7:0] c, input logic [7:0] v,
      input logic w);
      if (w)
      begin
         @(posedge clock);
         dat_wr <= 1'b1;
         dat_wdata <= v;
      end
      @(posedge clock);
      dat_wr <= 1'b0;
      dat_wdata <= ~dat_wdata;
      cmd_wr <= 1'b1;
      cmd_wdata <= c;
      @(posedge clock);
      cmd_wr <= 1'b0;
      cmd_wdata <= ~c;
      #1;
   endtask
   task automatic poll(output logic [7:0] d, output logic ok,
      output logic tmo);
      int n;
      n = 0;
      while (cmd_rdata[0] !== 1'b0 && n < 300)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      ok = cmd_rdata[1];
      d = ok ? dat_rdata : 8'h00;
      tmo = (n >= 300);
   endtask
endmodule
`default_nettype wire

/* File: testbench/hvr_regs_tb.sv */
// Purpose: self-checking bench of the config/status bank
// Assumes: clock enable held high
// Notes: random config bytes from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module hvr_regs_tb;
   logic clock, rst_n, irq_enable_mask, lin_short_raw, supply_low_raw;
   logic cmd_wr, dat_wr, hv_irq, lin_enable, lin_driver_on, atten_diag_on;
   logic [7:0] cmd_wdata, cmd_rdata, dat_wdata, dat_rdata, outs, d, r;
   logic ok;
   logic [31:0] seed;
   int fails, samples_checked, irqs;
   assign outs = {4'h0, hv_irq, lin_enable, lin_driver_on, atten_diag_on};
   hvr_regs hvr_regs_i
   (
      .clock(clock),
      .rst_n(rst_n),
      .ce(1'b1),
      .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata),
      .cmd_rdata(cmd_rdata),
      .dat_wr(dat_wr),
      .dat_wdata(dat_wdata),
      .dat_rdata(dat_rdata),
      .irq_enable_mask(irq_enable_mask),
      .lin_short_raw(lin_short_raw),
      .supply_low_raw(supply_low_raw),
      .hv_irq(hv_irq),
      .lin_enable(lin_enable),
      .lin_driver_on(lin_driver_on),
      .atten_diag_on(atten_diag_on)
   );
   hvr_core_model hvr_core_model_i
   (
      .clock(clock),
      .cmd_rdata(cmd_rdata),
      .dat_rdata(dat_rdata),
      .cmd_wr(cmd_wr),
      .cmd_wdata(cmd_wdata),
      .dat_wr(dat_wr),
      .dat_wdata(dat_wdata)
   );
   // ****************
   // helpers
   // ****************
   // 50 ns clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // expected control outputs after a config write
   function automatic logic [7:0] cfg_outs(input logic [7:0] c,
      input logic drv_ok);
      return {5'h0, c[0], c[0] & drv_ok, c[3]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic pl();
      logic t;
      hvr_core_model_i.poll(r, ok, t);
      if (t)
      begin
         fails++;
         summarize();
      end
   endtask
   task automatic xf(input logic [7:0] c, input logic [7:0] v);
      hvr_core_model_i.issue(c, v, c == hvr_pkg::CMD_WRITE_CFG);
      pl();
   endtask
   // config write then status read
   task automatic ws(input logic [7:0] c, input logic [7:0] e);
      xf(hvr_pkg::CMD_WRITE_CFG, c);
      xf(hvr_pkg::CMD_READ_STA, 8'h00);
      chk(r, e);
   endtask
   // raw short for n cycles, counts irq pulses
   task automatic shrt(input int n);
      irqs = 0;
      repeat (n + 12)
      begin
         @(posedge clock);
         lin_short_raw <= (n > 0);
         n--;
         #1;
         if (hv_irq === 1'b1)
            irqs++;
      end
   endtask
   // ****************
   // main sequence
   // ****************
   initial
   begin
      fails = 0;
      samples_checked = 0;
      seed = 32'h00009ab2;
      rst_n = 1'b0;
      irq_enable_mask = 1'b0;
      lin_short_raw = 1'b0;
      supply_low_raw = 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      chk(cmd_rdata | dat_rdata | outs, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0];
         xf(hvr_pkg::CMD_WRITE_CFG, d);
         chk(outs, cfg_outs(d, 1'b1));
         chk({7'h0, ok}, 8'h01);
         xf(hvr_pkg::CMD_READ_CFG, 8'h00);
         chk(r, d & 8'h1b);
      end
      xf(8'h7e, 8'h00);
      chk({7'h0, ok}, 8'h00);
      ws(8'h00, 8'h00);
      ws(8'h10, 8'h04);
      @(posedge clock);
      supply_low_raw <= 1'b1;
      repeat (4) @(posedge clock);
      supply_low_raw <= 1'b0;
      ws(8'h10, 8'h00);
      ws(8'h00, 8'h00);
      ws(8'h10, 8'h04);
      @(posedge clock);
      irq_enable_mask <= 1'b1;
      ws(8'h01, 8'h00);
      shrt(380);
      chk(irqs[7:0], 8'h00);
      chk(outs, 8'h06);
      seed = xs(seed);
      shrt(410 + int'(seed[5:0]));
      chk(irqs[7:0], 8'h01);
      pl();
      chk(r, 8'h01);
      chk(outs, 8'h04);
      ws(8'h01, 8'h00);
      chk(outs, 8'h04);
      ws(8'h05, 8'h00);
      chk(outs, 8'h06);
      ws(8'h03, 8'h00);
      shrt(450);
      chk(irqs[7:0], 8'h01);
      pl();
      chk(r, 8'h01);
      chk(outs, 8'h06);
      @(posedge clock);
      irq_enable_mask <= 1'b0;
      ws(8'h01, 8'h00);
      shrt(450);
      chk(irqs[7:0], 8'h00);
      chk(outs, 8'h04);
      xf(hvr_pkg::CMD_READ_STA, 8'h00);
      chk(r, 8'h01);
      xf(hvr_pkg::CMD_READ_STA, 8'h00);
      chk(r, 8'h00);
      summarize();
   end
endmodule
bind hvr_regs hvr_regs_props hvr_regs_props_i
(
   .clock(clock),
   .rst_n(rst_n),
   .cmd_wr(cmd_wr),
   .cmd_rdata(cmd_rdata),
   .dat_rdata(dat_rdata),
   .irq_enable_mask(irq_enable_mask),
   .lin_short_raw(lin_short_raw),
   .hv_irq(hv_irq),
   .lin_enable(lin_enable),
   .lin_driver_on(lin_driver_on)
);
`default_nettype wire
